// file: src/shpi_pkg.sv
package shpi_pkg;
// Function
// - one host interface picked by straps
// - straps latched after reset, held 10ms
// - registers are 256 words of 24 bits
// - register bits above address field ignored
// - reset reloads address register, catches pins
// - target identifier is address plus one
// - i2c address from register and pins
// - serial address from register and pins
// - link is 38400 baud, 8N1
// - direction pin high while selected
// - several commands, up to 252 bytes
// - select commands acknowledged on identifier match
// - deselect command drops selection, acknowledged
// - pointer clear and load commands
// - read commands with short or byte count
// - write commands, long form count minus 4
// - pointer advances past last accessed byte
// - invalid, reserved, unused codes end the packet with an error reply
// - reply opening codes for ack and report
// - error reply codes, else stay silent
// - auto report only while enable bit set
// - auto report carries eight measurement words

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD = 38400;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int CNT_W = $clog2(BIT_CYC);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYC / 2 - 1);
  localparam int STRAP_MS = 10;
  localparam int STRAP_CYC = (CLK_HZ / 1000) * STRAP_MS;

  // register space
  localparam int WORDS = 256;
  localparam int WORD_W = 24;
  localparam int BPW = 3;
  localparam int BUF_D = 256;
  localparam logic [15:0] DEVICE_ADDRESS_BYTE = 16'h002d;
  localparam logic [15:0] CMD_BYTE = 16'h0000;
  localparam logic [7:0] DEVICE_ADDRESS_WORD = 8'(DEVICE_ADDRESS_BYTE / BPW);
  localparam logic [7:0] CMD_WORD = 8'(CMD_BYTE / BPW);
  localparam int AR_BIT = 3;
  localparam logic [15:0] AR_FIRST = 16'h001b;
  localparam logic [15:0] AR_LAST = 16'h0030;
  localparam logic [7:0] AR_BYTES = 8'(AR_LAST - AR_FIRST + 16'(BPW));

  // packet layout
  localparam logic [7:0] HDR = 8'haa;
  localparam logic [7:0] MIN_LEN = 8'h03;
  localparam logic [7:0] FRAME_OVH = 8'h03;
  localparam logic [7:0] WR_OVH = 8'h04;
  localparam logic [7:0] PAY_IDX = 8'h02;
  localparam logic [7:0] MAX_XFER = 8'hfc;

  // host commands
  localparam logic [7:0] CMD_CLR = 8'ha0;
  localparam logic [7:0] CMD_SETL = 8'ha1;
  localparam logic [7:0] CMD_SETH = 8'ha2;
  localparam logic [7:0] CMD_SET16 = 8'ha3;
  localparam logic [7:0] CMD_DESEL = 8'hc0;
  localparam logic [7:0] CMD_SEL_LO = 8'hc1;
  localparam logic [7:0] CMD_SEL_HI = 8'hce;
  localparam logic [7:0] CMD_SEL = 8'hcf;
  localparam logic [7:0] CMD_WR = 8'hd0;
  localparam logic [7:0] CMD_RD = 8'he0;

  // reply codes
  localparam logic [7:0] REP_ACK_DATA = 8'haa;
  localparam logic [7:0] REP_AUTO = 8'hae;
  localparam logic [7:0] REP_ACK = 8'had;
  localparam logic [7:0] REP_NACK = 8'hb0;
  localparam logic [7:0] REP_UNIMP = 8'hbc;
  localparam logic [7:0] REP_CKSUM = 8'hbd;
  localparam logic [7:0] REP_OVF = 8'hbf;

  typedef enum logic [1:0] {
    IF_SPI = 2'b00, IF_UART = 2'b01, IF_I2C = 2'b10
  } shpi_if_t;

  typedef enum logic [3:0] {
    M_INIT = 4'b0000, M_RXPKT = 4'b0001, M_CHK = 4'b0010,
    M_X_CMD = 4'b0011, M_X_ARG = 4'b0100, M_X_RD = 4'b0101,
    M_X_RDB = 4'b0110, M_X_WR = 4'b0111, M_X_WR2 = 4'b1000,
    M_WAIT = 4'b1001, M_REPLY = 4'b1010, M_TX = 4'b1011,
    M_OFF = 4'b1100
  } shpi_st_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } shpi_rx_t;
endpackage

// file: src/shpi_mem.sv
`timescale 1ns/1ps
module shpi_mem #(
  parameter int W = 8,
  parameter int D = 256,
  parameter int AW = $clog2(D)
) (
  // clock and enable
  input wire logic sys_clk,
  input wire logic ce,
  // single port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [W-1:0] wd,
  output logic [W-1:0] q
);
  logic [W-1:0] mem [D];

  // read data registered, old word on a write cycle
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (we) mem[addr] <= wd;
      q <= mem[addr];
    end
  end
endmodule // shpi_mem

// file: src/shpi_core.sv
`timescale 1ns/1ps
module shpi_core import shpi_pkg::*; #(
  parameter int STRAP_CYCLES = STRAP_CYC,
  parameter bit PKG16 = 1'b0
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // strap and address pins
  input wire logic interface_config_pin,
  input wire logic select_direction_in,
  output logic select_direction_out,
  output logic select_direction_oe,
  input wire logic address_pin_low,
  input wire logic address_pin_high,
  // nonvolatile copy of the device address register
  input wire logic [WORD_W-1:0] nv_device_address,
  // serial link
  input wire logic uart_rx,
  output logic uart_tx,
  // accumulation interval done
  input wire logic accum_done,
  // status
  output shpi_if_t if_mode,
  output logic if_ready,
  output logic [8:0] target_identifier,
  output logic [6:0] i2c_address
);
  localparam int ICW = $clog2(STRAP_CYCLES + 1);

  shpi_st_t st_reg, st_next, ret_reg, ret_next;
  shpi_rx_t rx_st_reg, rx_st_next;
  shpi_if_t mode_next;
  logic [ICW-1:0] icnt_reg, icnt_next;
  logic [CNT_W-1:0] rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic rx_vld_reg, rx_vld_next;
  logic tx_busy_reg, tx_busy_next, tx_next;
  logic [8:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_n_reg, tx_n_next;
  logic ready_next, dir_next, oe_next;
  logic [8:0] id_next;
  logic [6:0] i2c_next;
  logic [7:0] addr_reg, addr_next, pidx_reg, pidx_next, plen_reg, plen_next;
  logic [7:0] sum_reg, sum_next, idx_reg, idx_next, op_reg, op_next;
  logic [7:0] cnt_reg, cnt_next, rlen_reg, rlen_next, code_reg, code_next;
  logic [7:0] txi_reg, txi_next, txsum_reg, txsum_next;
  logic [7:0] tx_byte_reg, tx_byte_next;
  logic [15:0] ptr_reg, ptr_next, sav_reg, sav_next;
  logic sel_reg, sel_next, was_reg, was_next, auto_reg, auto_next;
  logic arg2_reg, arg2_next, ar_reg, ar_next, rdc_reg, rdc_next;
  logic tx_go_reg, tx_go_next;
  logic uart_on, tx_busy, has_data;
  logic [7:0] ck_idx, tx_total, pq, rb_q, rbyte, ram_addr, pb_addr, rb_addr;
  logic [1:0] lane;
  logic [WORD_W-1:0] ram_q, ram_wd, wmerge;
  logic ram_we, pb_we, rb_we;

  // register space and the two packet buffers
  shpi_mem #(.W(WORD_W), .D(WORDS)) u_ram (
    .sys_clk(sys_clk), .ce(ce), .we(ram_we), .addr(ram_addr),
    .wd(ram_wd), .q(ram_q));
  shpi_mem #(.W(8), .D(BUF_D)) u_pbuf (
    .sys_clk(sys_clk), .ce(ce), .we(pb_we), .addr(pb_addr),
    .wd(rx_sh_reg), .q(pq));
  shpi_mem #(.W(8), .D(BUF_D)) u_rbuf (
    .sys_clk(sys_clk), .ce(ce), .we(rb_we), .addr(rb_addr),
    .wd(rbyte), .q(rb_q));

  // byte lanes: lane 0 is bits 7:0 of a word
  assign lane = 2'(ptr_reg % 16'(BPW));
  assign rbyte = 8'(ram_q >> {lane, 3'b000});
  assign ck_idx = plen_reg - 8'h01;
  assign uart_on = if_ready && (if_mode == IF_UART);
  assign tx_busy = tx_busy_reg || tx_go_reg;
  assign has_data = (code_reg == REP_ACK_DATA) || (code_reg == REP_AUTO);
  assign tx_total = has_data ? rlen_reg + FRAME_OVH : 8'h01;

  always_comb begin
    wmerge = ram_q;
    unique case (lane)
      2'd0: wmerge[7:0] = pq;
      2'd1: wmerge[15:8] = pq;
      default: wmerge[23:16] = pq;
    endcase
  end

  // receiver: start bit checked at mid bit, then one bit period steps
  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_vld_next = 1'b0;
    unique case (rx_st_reg)
      RX_IDLE: if (uart_on && !uart_rx) begin
        rx_st_next = RX_START;
        rx_cnt_next = HALF_BIT;
      end
      RX_START: if (rx_cnt_reg != '0) rx_cnt_next = rx_cnt_reg - 1'b1;
      else begin
        rx_st_next = uart_rx ? RX_IDLE : RX_DATA; // glitch rejected
        rx_cnt_next = BIT_LAST;
        rx_bit_next = '0;
      end
      RX_DATA: if (rx_cnt_reg != '0) rx_cnt_next = rx_cnt_reg - 1'b1;
      else begin
        rx_sh_next = {uart_rx, rx_sh_reg[7:1]};
        rx_cnt_next = BIT_LAST;
        rx_bit_next = rx_bit_reg + 3'd1;
        if (rx_bit_reg == 3'd7) rx_st_next = RX_STOP;
      end
      RX_STOP: if (rx_cnt_reg != '0) rx_cnt_next = rx_cnt_reg - 1'b1;
      else begin
        rx_vld_next = uart_rx; // framing error drops the byte
        rx_st_next = RX_IDLE;
      end
    endcase
  end

  // transmitter: start, eight data bits lsb first, one stop
  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_sh_next = tx_sh_reg;
    tx_n_next = tx_n_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_next = uart_tx;
    if (!tx_busy_reg) begin
      tx_next = 1'b1;
      if (tx_go_reg) begin
        tx_busy_next = 1'b1;
        tx_sh_next = {1'b1, tx_byte_reg};
        tx_n_next = 4'd0;
        tx_cnt_next = BIT_LAST;
        tx_next = 1'b0;
      end
    end else if (tx_cnt_reg != '0) tx_cnt_next = tx_cnt_reg - 1'b1;
    else if (tx_n_reg == 4'd9) tx_busy_next = 1'b0;
    else begin
      tx_next = tx_sh_reg[0];
      tx_sh_next = {1'b1, tx_sh_reg[8:1]};
      tx_n_next = tx_n_reg + 4'd1;
      tx_cnt_next = BIT_LAST;
    end
  end

  // packet engine: receive, verify, execute, reply
  always_comb begin
    st_next = st_reg; ret_next = ret_reg; icnt_next = icnt_reg;
    mode_next = if_mode; ready_next = if_ready;
    id_next = target_identifier; i2c_next = i2c_address;
    addr_next = addr_reg; pidx_next = pidx_reg; plen_next = plen_reg;
    sum_next = sum_reg; idx_next = idx_reg; op_next = op_reg;
    cnt_next = cnt_reg; rlen_next = rlen_reg; code_next = code_reg;
    txi_next = txi_reg; txsum_next = txsum_reg;
    tx_byte_next = tx_byte_reg; tx_go_next = 1'b0;
    ptr_next = ptr_reg; sav_next = sav_reg; sel_next = sel_reg;
    was_next = was_reg; auto_next = auto_reg; arg2_next = arg2_reg;
    ram_addr = 8'(ptr_reg / 16'(BPW));
    ram_we = 1'b0;
    ram_wd = wmerge;
    pb_we = 1'b0;
    rb_we = 1'b0;
    unique case (st_reg)
      M_INIT: if (icnt_reg != '0) icnt_next = icnt_reg - 1'b1;
      else begin
        ready_next = 1'b1;
        if (!interface_config_pin) mode_next = IF_SPI;
        else mode_next = select_direction_in ? IF_I2C : IF_UART;
        addr_next = PKG16 ? {nv_device_address[7:1], address_pin_low}
          : {nv_device_address[7:2], address_pin_high,
             address_pin_low};
        i2c_next = PKG16 ? {nv_device_address[5:0], address_pin_low}
          : {nv_device_address[4:0], address_pin_high,
             address_pin_low};
        id_next = {1'b0, addr_next} + 9'h001;
        ram_addr = DEVICE_ADDRESS_WORD;
        ram_we = 1'b1;
        ram_wd = nv_device_address;
        // spi and i2c framing live elsewhere
        st_next = (mode_next == IF_UART) ? M_RXPKT : M_OFF;
      end
      M_RXPKT: begin
        ram_addr = CMD_WORD;
        if (rx_vld_reg) begin
          pb_we = 1'b1;
          if (pidx_reg == '0) begin
            if (rx_sh_reg == HDR) begin
              pidx_next = 8'h01;
              sum_next = rx_sh_reg;
            end
          end else begin
            pidx_next = pidx_reg + 8'h01;
            sum_next = sum_reg + rx_sh_reg;
            if (pidx_reg == 8'h01) begin
              plen_next = rx_sh_reg;
              // too short to frame: dropped, host times out
              if (rx_sh_reg < MIN_LEN) pidx_next = '0;
            end else if (pidx_next == plen_reg) st_next = M_CHK;
          end
        end else if (pidx_reg == '0 && accum_done && ar_reg) begin
          auto_next = 1'b1;
          sav_next = ptr_reg;
          ptr_next = AR_FIRST;
          cnt_next = AR_BYTES;
          rlen_next = '0;
          code_next = REP_AUTO;
          st_next = M_X_RD;
        end
      end
      M_CHK: begin
        was_next = sel_reg;
        rlen_next = '0;
        idx_next = PAY_IDX;
        pidx_next = '0;
        if (sum_reg != '0) begin
          code_next = REP_CKSUM;
          st_next = M_REPLY;
        end else begin
          code_next = REP_ACK;
          ret_next = M_X_CMD;
          st_next = M_WAIT;
        end
      end
      M_X_CMD: begin
        op_next = pq;
        idx_next = idx_reg + 8'h01;
        arg2_next = 1'b0;
        ret_next = M_X_CMD;
        st_next = M_WAIT;
        if (idx_reg == ck_idx) st_next = M_REPLY;
        else if (!sel_reg && pq != CMD_SEL
                 && !(pq >= CMD_SEL_LO && pq <= CMD_SEL_HI))
          st_next = M_REPLY;
        else if (!pq[7]) begin
          code_next = REP_NACK;
          st_next = M_REPLY;
        end else if (pq == CMD_CLR) ptr_next = '0;
        else if (pq == CMD_SETL || pq == CMD_SETH || pq == CMD_SET16
                 || pq == CMD_SEL || pq == CMD_RD)
          ret_next = M_X_ARG;
        else if (pq == CMD_DESEL) sel_next = 1'b0;
        else if (pq >= CMD_SEL_LO && pq <= CMD_SEL_HI)
          sel_next = ({5'h00, pq[3:0]} == target_identifier);
        else if (pq[7:4] == CMD_WR[7:4]) begin
          cnt_next = (pq[3:0] == 4'h0) ? plen_reg - WR_OVH
            : {4'h0, pq[3:0]};
          ret_next = M_X_WR;
        end else if (pq[7:4] == CMD_RD[7:4]) begin
          cnt_next = {4'h0, pq[3:0]};
          ret_next = M_X_RD;
        end else begin
          code_next = REP_UNIMP;
          st_next = M_REPLY;
        end
      end
      M_X_ARG: begin
        idx_next = idx_reg + 8'h01;
        ret_next = M_X_CMD;
        st_next = M_WAIT;
        if (idx_reg == ck_idx) begin
          code_next = REP_UNIMP; // missing parameter byte
          st_next = M_REPLY;
        end else begin
          case (op_reg)
            CMD_SETL: ptr_next[7:0] = pq;
            CMD_SETH: ptr_next[15:8] = pq;
            CMD_SET16: if (!arg2_reg) begin
              ptr_next[7:0] = pq;
              arg2_next = 1'b1;
              ret_next = M_X_ARG;
            end else ptr_next[15:8] = pq;
            CMD_SEL: sel_next = ({1'b0, pq} == target_identifier);
            default: begin
              cnt_next = pq;
              ret_next = M_X_RD;
            end
          endcase
        end
      end
      M_X_RD: if (cnt_reg == '0) begin
        if (auto_reg) begin
          ptr_next = sav_reg; // report leaves the host pointer alone
          st_next = M_REPLY;
        end else st_next = M_X_CMD;
      end else if (rlen_reg == MAX_XFER) begin
        code_next = REP_OVF;
        st_next = M_REPLY;
      end else st_next = M_X_RDB;
      M_X_RDB: begin
        rb_we = 1'b1;
        rlen_next = rlen_reg + 8'h01;
        ptr_next = ptr_reg + 16'h0001;
        cnt_next = cnt_reg - 8'h01;
        st_next = M_X_RD;
      end
      M_X_WR: if (cnt_reg == '0) st_next = M_X_CMD;
      else if (idx_reg == ck_idx) begin
        code_next = REP_OVF; // count runs past the packet
        st_next = M_REPLY;
      end else st_next = M_X_WR2;
      M_X_WR2: begin
        ram_we = 1'b1;
        idx_next = idx_reg + 8'h01;
        ptr_next = ptr_reg + 16'h0001;
        cnt_next = cnt_reg - 8'h01;
        ret_next = M_X_WR;
        st_next = M_WAIT;
      end
      M_WAIT: st_next = ret_reg; // buffer read latency
      M_REPLY: begin
        txi_next = '0;
        txsum_next = '0;
        st_next = M_TX;
        if (!was_reg && !sel_reg && !auto_reg) st_next = M_RXPKT;
        else if (code_reg == REP_ACK && rlen_reg != '0)
          code_next = REP_ACK_DATA;
      end
      M_TX: if (!tx_busy) begin
        if (txi_reg == tx_total) begin
          auto_next = 1'b0;
          st_next = M_RXPKT;
        end else begin
          tx_go_next = 1'b1;
          txi_next = txi_reg + 8'h01;
          if (txi_reg == '0) tx_byte_next = code_reg;
          else if (txi_reg == 8'h01)
            tx_byte_next = tx_total;
          else if (txi_reg == tx_total - 8'h01)
            tx_byte_next = 8'h00 - txsum_reg;
          else tx_byte_next = rb_q;
          txsum_next = txsum_reg + tx_byte_next;
        end
      end
      M_OFF: st_next = M_OFF;
      default: st_next = M_INIT;
    endcase
    pb_addr = (st_reg == M_RXPKT) ? pidx_reg : idx_reg;
    rb_addr = (st_reg == M_X_RDB) ? rlen_reg : txi_reg - PAY_IDX;
    // enable bit valid only one cycle after its word was addressed
    rdc_next = (ram_addr == CMD_WORD) && !ram_we;
    ar_next = rdc_reg ? ram_q[AR_BIT] : ar_reg;
    dir_next = sel_next || (st_next == M_TX);
    oe_next = ready_next && (mode_next == IF_UART);
  end

  // one register bank for all three groups
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= M_INIT; ret_reg <= M_INIT; icnt_reg <= ICW'(STRAP_CYCLES);
      rx_st_reg <= RX_IDLE; rx_cnt_reg <= '0; rx_bit_reg <= '0;
      rx_sh_reg <= '0; rx_vld_reg <= 1'b0;
      tx_busy_reg <= 1'b0; tx_sh_reg <= '1; tx_n_reg <= '0;
      tx_cnt_reg <= '0; uart_tx <= 1'b1;
      if_mode <= IF_SPI; if_ready <= 1'b0;
      target_identifier <= '0; i2c_address <= '0; addr_reg <= '0;
      pidx_reg <= '0; plen_reg <= '0; sum_reg <= '0; idx_reg <= '0;
      op_reg <= '0; cnt_reg <= '0; rlen_reg <= '0; code_reg <= REP_ACK;
      txi_reg <= '0; txsum_reg <= '0; tx_byte_reg <= '0;
      tx_go_reg <= 1'b0; ptr_reg <= '0; sav_reg <= '0;
      sel_reg <= 1'b0; was_reg <= 1'b0; auto_reg <= 1'b0;
      arg2_reg <= 1'b0; ar_reg <= 1'b0; rdc_reg <= 1'b0;
      select_direction_out <= 1'b0; select_direction_oe <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next; ret_reg <= ret_next; icnt_reg <= icnt_next;
      rx_st_reg <= rx_st_next; rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next; rx_sh_reg <= rx_sh_next;
      rx_vld_reg <= rx_vld_next;
      tx_busy_reg <= tx_busy_next; tx_sh_reg <= tx_sh_next;
      tx_n_reg <= tx_n_next; tx_cnt_reg <= tx_cnt_next; uart_tx <= tx_next;
      if_mode <= mode_next; if_ready <= ready_next;
      target_identifier <= id_next; i2c_address <= i2c_next;
      addr_reg <= addr_next;
      pidx_reg <= pidx_next; plen_reg <= plen_next; sum_reg <= sum_next;
      idx_reg <= idx_next; op_reg <= op_next; cnt_reg <= cnt_next;
      rlen_reg <= rlen_next; code_reg <= code_next;
      txi_reg <= txi_next; txsum_reg <= txsum_next;
      tx_byte_reg <= tx_byte_next; tx_go_reg <= tx_go_next;
      ptr_reg <= ptr_next; sav_reg <= sav_next;
      sel_reg <= sel_next; was_reg <= was_next; auto_reg <= auto_next;
      arg2_reg <= arg2_next; ar_reg <= ar_next; rdc_reg <= rdc_next;
      select_direction_out <= dir_next; select_direction_oe <= oe_next;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_IF_PICK: assert property ($rose(if_ready) |-> if_mode ==
    (!$past(interface_config_pin) ? IF_SPI
     : ($past(select_direction_in) ? IF_I2C : IF_UART)))
    else $error("interface mode does not follow straps");
  AST_STRAP_HOLD: assert property (
    (st_reg == M_INIT && icnt_reg != '0) |-> !if_ready)
    else $error("interface ready before strap time");
  AST_ID_PLUS1: assert property (
    if_ready |-> target_identifier == {1'b0, addr_reg} + 9'h001)
    else $error("identifier is not address plus one");
  AST_ADDR_PINS: assert property ($rose(if_ready) && !PKG16 |->
    addr_reg[1:0] == {$past(address_pin_high), $past(address_pin_low)})
    else $error("address low bits not from pins");
  AST_DIR_SEL: assert property (sel_reg |-> select_direction_out)
    else $error("direction low while selected");
  AST_QUIET: assert property (
    (!sel_reg && st_reg != M_TX) |-> !select_direction_out && !tx_go_reg)
    else $error("unselected device drives the bus");
  AST_CKSUM: assert property (
    (ce && st_reg == M_CHK && sum_reg != '0) |=>
      code_reg == REP_CKSUM ##0 st_reg == M_REPLY)
    else $error("bad checksum not reported");
  AST_PTR_STEP: assert property (
    (ce && st_reg == M_X_RDB) |=> ptr_reg == $past(ptr_reg) + 16'h0001)
    else $error("pointer did not advance on read");
  AST_CLR: assert property ((ce && st_reg == M_X_CMD && sel_reg
    && idx_reg != ck_idx && pq == CMD_CLR) |=> ptr_reg == '0)
    else $error("pointer clear failed");
  AST_AUTO_EN: assert property ($rose(auto_reg) |-> $past(ar_reg))
    else $error("auto report without enable");
  AST_TX_IDLE: assert property (
    (!tx_busy_reg && !$past(tx_go_reg)) |-> uart_tx)
    else $error("line not idle high");

  CV_DATA: cover property (st_reg == M_TX && code_reg == REP_ACK_DATA);
  CV_CKSUM: cover property (st_reg == M_REPLY && code_reg == REP_CKSUM);
  CV_AUTO: cover property (st_reg == M_TX && code_reg == REP_AUTO);
endmodule // shpi_core

// file: bench/shpi_host.sv
`timescale 1ns/1ps
module shpi_host import shpi_pkg::*; (
  // clock
  input wire logic sys_clk,
  // serial link, host side
  output logic uart_rx,
  input wire logic uart_tx
);
  // line idles high between frames
  initial uart_rx = 1'b1;

  // one 8N1 frame, lsb first; the stop bit is left standing on return,
  // so a reply that starts mid stop bit is not missed by the receiver
  task automatic send_byte(input logic [7:0] b);
    logic [8:0] f;
    f = {b, 1'b0};
    repeat (BIT_CYC) @(posedge sys_clk); // stop of the last frame or idle
    for (int i = 0; i < 9; i++) begin
      uart_rx <= f[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    uart_rx <= 1'b1;
  endtask

  // bounded wait for a start bit, then mid-bit sampling
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (uart_tx !== 1'b0 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      b[i] = uart_tx;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
    ok = (n < 20000) && (uart_tx === 1'b1);
  endtask
endmodule // shpi_host

// file: bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  mismatches++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); \
  end end
module tb_top import shpi_pkg::*; ();
  // clock, reset and pins
  logic sys_clk, rst, ce, cfg_pin, dir_in, dir_out, dir_oe;
  logic a_lo, a_hi, uart_rx, uart_tx, accum_done, if_ready;
  logic [23:0] nv_addr;
  shpi_if_t if_mode;
  logic [8:0] tid;
  logic [6:0] i2c;
  int mismatches, comparisons;

  shpi_core #(.STRAP_CYCLES(20)) dut (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .interface_config_pin(cfg_pin), .select_direction_in(dir_in),
    .select_direction_out(dir_out), .select_direction_oe(dir_oe),
    .address_pin_low(a_lo), .address_pin_high(a_hi),
    .nv_device_address(nv_addr), .uart_rx(uart_rx), .uart_tx(uart_tx),
    .accum_done(accum_done), .if_mode(if_mode), .if_ready(if_ready),
    .target_identifier(tid), .i2c_address(i2c));
  shpi_host host (.sys_clk(sys_clk), .uart_rx(uart_rx),
    .uart_tx(uart_tx));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // appends the checksum so the packet sums to zero
  task automatic send_pkt(input logic [7:0] p [7]);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 7; i++) begin
      s += p[i];
      host.send_byte(p[i]);
    end
    host.send_byte(8'h00 - s);
  endtask

  // a full run is about 94k cycles
  initial begin
    repeat (98000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end

  // reset with the given straps held, then wait for them to be latched
  task automatic strap_reset(input logic cfg, dir, hi, lo);
    int n;
    rst <= 1'b1;
    cfg_pin <= cfg;
    dir_in <= dir;
    a_hi <= hi;
    a_lo <= lo;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    n = 0;
    while (if_ready !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    `CHK(if_ready, 1'b1)
  endtask

  initial begin
    logic [7:0] pkt [7];
    logic [7:0] exp [5];
    logic [7:0] b, s;
    logic ok;
    ce = 1'b1;
    nv_addr = 24'h012345; // upper bits set on purpose, must be ignored
    accum_done = 1'b0;
    mismatches = 0;
    comparisons = 0;
    strap_reset(1'b1, 1'b0, 1'b0, 1'b1);
    `CHK(if_mode, IF_UART)
    `CHK(dir_oe, 1'b1)
    `CHK(tid, 9'h046)
    `CHK(i2c, 7'h15)
    `CHK(dir_out, 1'b0)
    $display("test straps done");
    // select, pointer to the address word, read three bytes
    pkt = '{HDR, 8'h08, CMD_SEL, 8'h46, CMD_SETL, 8'h2d, 8'he3};
    exp = '{REP_ACK_DATA, 8'h06, 8'h45, 8'h23, 8'h01};
    send_pkt(pkt);
    s = 8'h00;
    for (int i = 0; i < 6; i++) begin
      host.recv_byte(b, ok);
      `CHK(ok, 1'b1)
      if (i < 5) `CHK(b, exp[i])
      s += b;
    end
    `CHK(s, 8'h00)
    `CHK(dir_out, 1'b1)
    $display("test select_read done");
    // empty payload, checksum byte wrong: one code byte comes back
    host.send_byte(HDR);
    host.send_byte(8'h03);
    host.send_byte(8'h00);
    host.recv_byte(b, ok);
    `CHK(ok, 1'b1)
    `CHK(b, REP_CKSUM)
    $display("test checksum done");
    // other straps and address pins; reset also drops the selection
    strap_reset(1'b1, 1'b1, 1'b0, 1'b1);
    `CHK(if_mode, IF_I2C)
    `CHK(dir_oe, 1'b0)
    `CHK(dir_out, 1'b0)
    strap_reset(1'b0, 1'b1, 1'b1, 1'b0);
    `CHK(if_mode, IF_SPI)
    `CHK(tid, 9'h047)
    `CHK(i2c, 7'h16)
    $display("test modes done");
    end_of_test();
  end
endmodule // tb_top
